// File: src/dqtf_regs.vh
`ifndef DQTF_REGS_VH
`define DQTF_REGS_VH

// ==========================================================
// Register byte offsets
`define DQTF_OFS_PAT_FIRST   8'h00
`define DQTF_OFS_PAT_SECOND  8'h04
`define DQTF_OFS_MASK_LOWER  8'h08
`define DQTF_OFS_MASK_UPPER  8'h0C
`define DQTF_OFS_INV_CTRL    8'h10
`define DQTF_OFS_LAT_CFG     8'h14
`define DQTF_OFS_STATUS      8'h18

// ==========================================================
// Reset values
`define DQTF_RST_PAT_FIRST   8'h5A
`define DQTF_RST_PAT_SECOND  8'h3C
`define DQTF_RST_MASK        8'h55
`define DQTF_RST_INV_CTRL    8'h00
`define DQTF_RST_RL          6'h0E
`define DQTF_RST_WL          6'h08

// ==========================================================
// Field positions
`define DQTF_BIT_READ_BUS_INVERSION      6
`define DQTF_BIT_DBI_WR      7
`define DQTF_LAT_WL_LSB      8
`define DQTF_LAT_BYTE_SEL    16
`define DQTF_STAT_RD_LSB     4
`define DQTF_BIT_MPC_EN      6

// ==========================================================
// Command codes on the link command pins
`define DQTF_CMD_MPC         4'h1
`define DQTF_CMD_CAS2        4'h2
`define DQTF_CMD_RD          4'h3

// Training function codes in operand bits 5..0
`define DQTF_OP_RD_FIFO      6'h01
`define DQTF_OP_RD_CAL       6'h03
`define DQTF_OP_WR_FIFO      6'h07

// Pending training kinds
`define DQTF_K_NONE          2'h0
`define DQTF_K_RD_FIFO       2'h1
`define DQTF_K_RD_CAL        2'h2
`define DQTF_K_WR_FIFO       2'h3

// ==========================================================
// Timing counts and bus response codes
`define DQTF_LAST_BEAT       4'hF
`define DQTF_AXI_OKAY        2'h0
`define DQTF_AXI_SLVERR      2'h2

`endif

// File: src/dqtf_mod_ptr.v
`timescale 1ns/1ps

// ==========================================================
// Modulo-N pointer, clear has priority over advance
module dqtf_mod_ptr #(
    parameter DEPTH = 5
) (
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Control
    input  wire       clr,
    input  wire       inc,
    // Pointer value
    output reg  [2:0] ptr_r
);

    localparam [2:0] LAST = DEPTH - 1;

    // Wraps after the last entry back to zero
    always @(posedge aclk)
    begin
        if (!aresetn)
            ptr_r <= 3'h0;
        else if (clr)
            ptr_r <= 3'h0;
        else if (inc)
            ptr_r <= (ptr_r == LAST) ? 3'h0 : ptr_r + 3'h1;
    end

endmodule // dqtf_mod_ptr

// File: src/dqtf_top.v
`timescale 1ns/1ps
`include "dqtf_regs.vh"

module dqtf_top #(
    parameter FIFO_DEPTH = 5
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Link inputs from the controller
    input  wire        link_ck,
    input  wire        link_cke,
    input  wire        link_reset_n,
    input  wire [3:0]  link_cmd,
    input  wire [6:0]  link_op,
    input  wire [15:0] dq_in,
    input  wire [1:0]  mask_inversion_pin_in,
    // Pin drivers, enable low while driving
    output reg  [15:0] dq_out,
    output reg  [15:0] dq_oe_n,
    output reg  [1:0]  mask_inversion_pin_out,
    output reg  [1:0]  mask_inversion_pin_oe_n
);

    localparam         SYNC_W  = 32;
    localparam         DL      = 64;
    localparam         MEM_N   = FIFO_DEPTH * 16;

    // ======================================================
    // Registers
    reg  [7:0]         cal_pattern_first_r;
    reg  [7:0]         cal_pattern_second_r;
    reg  [7:0]         invert_mask_lower_r;
    reg  [7:0]         invert_mask_upper_r;
    reg  [7:0]         inversion_control_reg_r;
    reg  [5:0]         rl_r;
    reg  [5:0]         wl_r;
    reg                byte_sel_r;
    reg                aw_got_r;
    reg                w_got_r;
    reg  [7:0]         awaddr_r;
    reg  [31:0]        wdata_r;
    reg  [3:0]         wstrb_r;
    reg  [31:0]        rd_word;
    reg                rd_ok;
    reg                wr_ok;
    reg  [31:0]        old_word;
    reg  [31:0]        new_word;
    wire [2:0]         wr_ptr;
    wire [2:0]         rd_ptr;

    // Byte lane merge under write strobes
    function [31:0] merge_strb;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      b;
        begin
            merge_strb = old_v;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    merge_strb[b*8 +: 8] = new_v[b*8 +: 8];
        end
    endfunction

    // Read decode, unmapped answers with error and zero data
    always @*
    begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `DQTF_OFS_PAT_FIRST:  rd_word[7:0] = cal_pattern_first_r;
            `DQTF_OFS_PAT_SECOND: rd_word[7:0] = cal_pattern_second_r;
            `DQTF_OFS_MASK_LOWER: rd_word[7:0] = invert_mask_lower_r;
            `DQTF_OFS_MASK_UPPER: rd_word[7:0] = invert_mask_upper_r;
            `DQTF_OFS_INV_CTRL:   rd_word[7:0] = inversion_control_reg_r;
            `DQTF_OFS_LAT_CFG:
            begin
                rd_word[5:0]                    = rl_r;
                rd_word[`DQTF_LAT_WL_LSB +: 6]  = wl_r;
                rd_word[`DQTF_LAT_BYTE_SEL]     = byte_sel_r;
            end
            `DQTF_OFS_STATUS:
            begin
                rd_word[2:0]                    = wr_ptr;
                rd_word[`DQTF_STAT_RD_LSB +: 3] = rd_ptr;
            end
            default:              rd_ok = 1'b0;
        endcase
    end

    // Current value of the addressed writable word
    always @*
    begin
        old_word = 32'h00000000;
        wr_ok    = 1'b1;
        case (awaddr_r)
            `DQTF_OFS_PAT_FIRST:  old_word[7:0] = cal_pattern_first_r;
            `DQTF_OFS_PAT_SECOND: old_word[7:0] = cal_pattern_second_r;
            `DQTF_OFS_MASK_LOWER: old_word[7:0] = invert_mask_lower_r;
            `DQTF_OFS_MASK_UPPER: old_word[7:0] = invert_mask_upper_r;
            `DQTF_OFS_INV_CTRL:   old_word[7:0] = inversion_control_reg_r;
            `DQTF_OFS_LAT_CFG:
            begin
                old_word[5:0]                   = rl_r;
                old_word[`DQTF_LAT_WL_LSB +: 6] = wl_r;
                old_word[`DQTF_LAT_BYTE_SEL]    = byte_sel_r;
            end
            default:              wr_ok = 1'b0;
        endcase
        new_word = merge_strb(old_word, wdata_r, wstrb_r);
    end

    // AXI4-Lite slave, address and data taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready           <= 1'b1;
            s_axi_wready            <= 1'b1;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= `DQTF_AXI_OKAY;
            s_axi_arready           <= 1'b1;
            s_axi_rvalid            <= 1'b0;
            s_axi_rresp             <= `DQTF_AXI_OKAY;
            s_axi_rdata             <= 32'h00000000;
            aw_got_r                <= 1'b0;
            w_got_r                 <= 1'b0;
            awaddr_r                <= 8'h00;
            wdata_r                 <= 32'h00000000;
            wstrb_r                 <= 4'h0;
            cal_pattern_first_r     <= `DQTF_RST_PAT_FIRST;
            cal_pattern_second_r    <= `DQTF_RST_PAT_SECOND;
            invert_mask_lower_r     <= `DQTF_RST_MASK;
            invert_mask_upper_r     <= `DQTF_RST_MASK;
            inversion_control_reg_r <= `DQTF_RST_INV_CTRL;
            rl_r                    <= `DQTF_RST_RL;
            wl_r                    <= `DQTF_RST_WL;
            byte_sel_r              <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `DQTF_AXI_OKAY : `DQTF_AXI_SLVERR;
                case (awaddr_r)
                    `DQTF_OFS_PAT_FIRST:  cal_pattern_first_r     <= new_word[7:0];
                    `DQTF_OFS_PAT_SECOND: cal_pattern_second_r    <= new_word[7:0];
                    `DQTF_OFS_MASK_LOWER: invert_mask_lower_r     <= new_word[7:0];
                    `DQTF_OFS_MASK_UPPER: invert_mask_upper_r     <= new_word[7:0];
                    `DQTF_OFS_INV_CTRL:   inversion_control_reg_r <= new_word[7:0];
                    `DQTF_OFS_LAT_CFG:
                    begin
                        rl_r       <= new_word[5:0];
                        wl_r       <= new_word[`DQTF_LAT_WL_LSB +: 6];
                        byte_sel_r <= new_word[`DQTF_LAT_BYTE_SEL];
                    end
                    default:              cal_pattern_first_r     <= cal_pattern_first_r;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_ok ? `DQTF_AXI_OKAY : `DQTF_AXI_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ======================================================
    // Link sampling
    reg  [SYNC_W-1:0]  s1_r;
    reg  [SYNC_W-1:0]  s2_r;
    reg  [SYNC_W-1:0]  s3_r;
    reg  [SYNC_W-1:0]  f_r;
    reg                ck_d_r;
    reg                cke_prev_r;
    wire               f_ck    = f_r[0];
    wire               f_cke   = f_r[1];
    wire               f_rst_n = f_r[2];
    wire [3:0]         f_cmd   = f_r[6:3];
    wire [6:0]         f_op    = f_r[13:7];
    wire [17:0]        f_data  = f_r[31:14];
    wire               lk_rise = f_ck & ~ck_d_r;

    // Three stages; a bit moves only once stages two and three agree
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_r       <= 32'h00000000;
            s2_r       <= 32'h00000000;
            s3_r       <= 32'h00000000;
            f_r        <= 32'h00000000;
            ck_d_r     <= 1'b0;
            cke_prev_r <= 1'b0;
        end
        else
        begin
            s1_r   <= {mask_inversion_pin_in, dq_in, link_op, link_cmd,
                       link_reset_n, link_cke, link_ck};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            f_r    <= (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
            ck_d_r <= f_ck;
            if (lk_rise)
                cke_prev_r <= f_cke;
        end
    end

    // ======================================================
    // Command decode and pointers
    reg  [1:0]         mpc_kind_r;
    reg  [1:0]         mpc_dec;
    wire               fire     = lk_rise && (mpc_kind_r != `DQTF_K_NONE) &&
                                  (f_cmd == `DQTF_CMD_CAS2);
    wire               norm_rd  = lk_rise && (f_cmd == `DQTF_CMD_RD);
    wire               cke_fall = lk_rise & cke_prev_r & ~f_cke;
    wire               ptr_clr  = ~f_rst_n | cke_fall;
    wire               inc_wr   = (fire && (mpc_kind_r == `DQTF_K_WR_FIFO)) || norm_rd;
    wire               inc_rd   = (fire && (mpc_kind_r == `DQTF_K_RD_FIFO)) || norm_rd;

    // Operand bit 6 low means nothing; unknown codes are ignored
    always @*
    begin
        mpc_dec = `DQTF_K_NONE;
        if (f_op[`DQTF_BIT_MPC_EN])
        begin
            case (f_op[5:0])
                `DQTF_OP_RD_FIFO: mpc_dec = `DQTF_K_RD_FIFO;
                `DQTF_OP_RD_CAL:  mpc_dec = `DQTF_K_RD_CAL;
                `DQTF_OP_WR_FIFO: mpc_dec = `DQTF_K_WR_FIFO;
                default:          mpc_dec = `DQTF_K_NONE;
            endcase
        end
    end

    // Held for one link edge; only a CAS-2 next edge fires it
    always @(posedge aclk)
    begin
        if (!aresetn)
            mpc_kind_r <= `DQTF_K_NONE;
        else if (lk_rise)
            mpc_kind_r <= (f_cmd == `DQTF_CMD_MPC) ? mpc_dec : `DQTF_K_NONE;
    end

    // Both pointers share one wrap rule and clear; only a normal read advances both
    dqtf_mod_ptr #(.DEPTH(FIFO_DEPTH)) u_wr_ptr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (ptr_clr),
        .inc     (inc_wr),
        .ptr_r   (wr_ptr)
    );

    dqtf_mod_ptr #(.DEPTH(FIFO_DEPTH)) u_rd_ptr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (ptr_clr),
        .inc     (inc_rd),
        .ptr_r   (rd_ptr)
    );

    // ======================================================
    // Latency delay lines, one slot per link edge
    reg  [1:0]         rdl_kind [0:DL-1];
    reg  [2:0]         rdl_ent  [0:DL-1];
    reg                wdl_v    [0:DL-1];
    reg  [2:0]         wdl_ent  [0:DL-1];
    integer            i;

    // Shift-register instead of a counter so bursts may overlap in flight
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < DL; i = i + 1)
            begin
                rdl_kind[i] <= `DQTF_K_NONE;
                rdl_ent[i]  <= 3'h0;
                wdl_v[i]    <= 1'b0;
                wdl_ent[i]  <= 3'h0;
            end
        end
        else if (lk_rise)
        begin
            for (i = DL - 1; i > 0; i = i - 1)
            begin
                rdl_kind[i] <= rdl_kind[i-1];
                rdl_ent[i]  <= rdl_ent[i-1];
                wdl_v[i]    <= wdl_v[i-1];
                wdl_ent[i]  <= wdl_ent[i-1];
            end
            rdl_kind[0] <= (fire && mpc_kind_r != `DQTF_K_WR_FIFO) ? mpc_kind_r
                                                                 : `DQTF_K_NONE;
            rdl_ent[0]  <= rd_ptr;
            wdl_v[0]    <= fire && (mpc_kind_r == `DQTF_K_WR_FIFO);
            wdl_ent[0]  <= wr_ptr;
        end
    end

    // ======================================================
    // Burst sequencers and training storage
    reg  [17:0]        mem [0:MEM_N-1];
    reg  [1:0]         rb_kind_r;
    reg  [2:0]         rb_ent_r;
    reg  [3:0]         rb_beat_r;
    reg  [1:0]         rb_kind_nxt;
    reg  [2:0]         rb_ent_nxt;
    reg  [3:0]         rb_beat_nxt;
    reg                wb_on_r;
    reg  [2:0]         wb_ent_r;
    reg  [3:0]         wb_beat_r;
    reg                wb_on_nxt;
    reg  [2:0]         wb_ent_nxt;
    reg  [3:0]         wb_beat_nxt;

    // A new tap preempts the old burst, which gives seamless bursts
    always @*
    begin
        rb_kind_nxt = rb_kind_r;
        rb_ent_nxt  = rb_ent_r;
        rb_beat_nxt = rb_beat_r;
        wb_on_nxt   = wb_on_r;
        wb_ent_nxt  = wb_ent_r;
        wb_beat_nxt = wb_beat_r;
        if (lk_rise)
        begin
            if (rdl_kind[rl_r] != `DQTF_K_NONE)
            begin
                rb_kind_nxt = rdl_kind[rl_r];
                rb_ent_nxt  = rdl_ent[rl_r];
                rb_beat_nxt = 4'h0;
            end
            else if (rb_kind_r != `DQTF_K_NONE && rb_beat_r != `DQTF_LAST_BEAT)
                rb_beat_nxt = rb_beat_r + 4'h1;
            else
                rb_kind_nxt = `DQTF_K_NONE;
            if (wdl_v[wl_r])
            begin
                wb_on_nxt   = 1'b1;
                wb_ent_nxt  = wdl_ent[wl_r];
                wb_beat_nxt = 4'h0;
            end
            else if (wb_on_r && wb_beat_r != `DQTF_LAST_BEAT)
                wb_beat_nxt = wb_beat_r + 4'h1;
            else
                wb_on_nxt   = 1'b0;
        end
    end

    // Storage clears only on aresetn, not on link reset, so unwritten entries read as clean levels
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < MEM_N; i = i + 1)
                mem[i] <= 18'h00000;
            rb_kind_r <= `DQTF_K_NONE;
            rb_ent_r  <= 3'h0;
            rb_beat_r <= 4'h0;
            wb_on_r   <= 1'b0;
            wb_ent_r  <= 3'h0;
            wb_beat_r <= 4'h0;
        end
        else
        begin
            if (lk_rise && wb_on_nxt)
                mem[{wb_ent_nxt, wb_beat_nxt}] <= f_data;
            rb_kind_r <= rb_kind_nxt;
            rb_ent_r  <= rb_ent_nxt;
            rb_beat_r <= rb_beat_nxt;
            wb_on_r   <= wb_on_nxt;
            wb_ent_r  <= wb_ent_nxt;
            wb_beat_r <= wb_beat_nxt;
        end
    end

    // ======================================================
    // Pin drive
    wire [15:0]        pat16   = {cal_pattern_second_r, cal_pattern_first_r};
    wire               cal_bit = pat16[rb_beat_nxt];
    wire               read_bus_inversion  = inversion_control_reg_r[`DQTF_BIT_READ_BUS_INVERSION];
    wire               dbi_wr  = inversion_control_reg_r[`DQTF_BIT_DBI_WR];
    wire [7:0]         lane_lo = {8{cal_bit}} ^ invert_mask_lower_r;
    wire [7:0]         lane_hi = {8{cal_bit}} ^ invert_mask_upper_r;
    wire [17:0]        rd_word_f = mem[{rb_ent_nxt, rb_beat_nxt}];

    // Registered pins; calibration applies the invert mask to its lane
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dq_out                  <= 16'h0000;
            dq_oe_n                 <= 16'hFFFF;
            mask_inversion_pin_out  <= 2'h0;
            mask_inversion_pin_oe_n <= 2'h3;
        end
        else if (rb_kind_nxt == `DQTF_K_RD_CAL)
        begin
            if (byte_sel_r)
            begin
                dq_out                  <= {lane_hi, 8'h00};
                dq_oe_n                 <= 16'h00FF;
                mask_inversion_pin_out  <= {cal_bit, 1'b0};
                mask_inversion_pin_oe_n <= {~read_bus_inversion, 1'b1};
            end
            else
            begin
                dq_out                  <= {8'h00, lane_lo};
                dq_oe_n                 <= 16'hFF00;
                mask_inversion_pin_out  <= {1'b0, cal_bit};
                mask_inversion_pin_oe_n <= {1'b1, ~read_bus_inversion};
            end
        end
        else if (rb_kind_nxt == `DQTF_K_RD_FIFO)
        begin
            dq_out                  <= rd_word_f[15:0];
            dq_oe_n                 <= 16'h0000;
            mask_inversion_pin_out  <= rd_word_f[17:16];
            mask_inversion_pin_oe_n <= {2{~(read_bus_inversion | dbi_wr)}};
        end
        else
        begin
            dq_out                  <= 16'h0000;
            dq_oe_n                 <= 16'hFFFF;
            mask_inversion_pin_out  <= 2'h0;
            mask_inversion_pin_oe_n <= 2'h3;
        end
    end

endmodule // dqtf_top

// File: testbench/dqtf_monitor.sv
`timescale 1ns/1ps
// ========
// Port checker for the bus handshakes and the pin drive shape
module dqtf_monitor (
    // Clock, reset, bus handshakes, pin enables
    input wire aclk, aresetn, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire [15:0] dq_oe_n,
    input wire [1:0] mask_inversion_pin_oe_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A beat stands a whole link period
    sequence s_bt; !(&dq_oe_n) [*8]; endsequence
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rh: assert property (p_rh) else $error("rvalid dropped");
    property p_bw; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_bw: assert property (p_bw) else $error("aw open");
    property p_rw; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rw: assert property (p_rw) else $error("ar open");
    property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_bd: assert property (p_bd) else $error("b stuck");
    property p_ln; dq_oe_n inside {16'hFFFF, 16'hFF00, 16'h00FF, 16'h0000}; endproperty
    a_ln: assert property (p_ln) else $error("lane");
    property p_bt; $fell(&dq_oe_n) |-> s_bt; endproperty
    a_bt: assert property (p_bt) else $error("beat");
    property p_dm; (mask_inversion_pin_oe_n[0] || !dq_oe_n[0]) &&
        (mask_inversion_pin_oe_n[1] || !dq_oe_n[8]); endproperty
    a_dm: assert property (p_dm) else $error("mask pin");
endmodule // dqtf_monitor
bind dqtf_top dqtf_monitor u_mon (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .s_axi_awready           (s_axi_awready),
    .s_axi_bvalid            (s_axi_bvalid),
    .s_axi_bready            (s_axi_bready),
    .s_axi_arready           (s_axi_arready),
    .s_axi_rvalid            (s_axi_rvalid),
    .s_axi_rready            (s_axi_rready),
    .dq_oe_n                 (dq_oe_n),
    .mask_inversion_pin_oe_n (mask_inversion_pin_oe_n)
);

// File: testbench/dqtf_ctl.sv
`timescale 1ns/1ps
// ========
// Controller model; idle data lines flip so stale bits never pass
module dqtf_ctl (
    input wire aclk,
    output logic link_ck, link_cke, link_reset_n,
    output logic [3:0] link_cmd,
    output logic [6:0] link_op,
    output logic [15:0] dq_in,
    output logic [1:0] mask_inversion_pin_in
);
    // Clock parked low, power and reset pins inactive
    initial {link_ck, link_cke, link_reset_n, link_cmd, link_op, dq_in} = 30'h1800_0000;
    initial mask_inversion_pin_in = 2'h0;
    // One 800 ns period; pins move only after aclk edges
    task lk(input [3:0] c, input [6:0] o, input [17:0] d, input v, input k);
        @(posedge aclk);
        link_cmd <= c;
        link_op <= o;
        link_cke <= k;
        {mask_inversion_pin_in, dq_in} <= v ? d : ~{mask_inversion_pin_in, dq_in};
        repeat (2) @(posedge aclk);
        link_ck <= 1'b1;
        repeat (4) @(posedge aclk);
        link_ck <= 1'b0;
        @(posedge aclk);
    endtask
    // Training command, CAS-2 with low operands, then idle edges only
    task train(input [6:0] o, input [17:0] d [16]);
        lk(4'h1, o, 18'h0, 1'b0, 1'b1);
        lk(4'h2, 7'h0, 18'h0, 1'b0, 1'b1);
        for (int e = 2; e < 34; e++)
            lk(4'h0, 7'h0, d[(e - 10) & 15], e > 9 && e < 26, 1'b1);
    endtask
endmodule // dqtf_ctl

// File: testbench/tb.sv
`timescale 1ns/1ps
// ========
// Bench: bus and link traffic, beats checked as they appear
module tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, seed = 32'h17EE;
    logic [3:0] s_axi_wstrb = 4'hF;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire link_ck, link_cke, link_reset_n;
    wire [1:0] s_axi_bresp, s_axi_rresp, mask_inversion_pin_in;
    wire [1:0] mask_inversion_pin_out, mask_inversion_pin_oe_n;
    wire [31:0] s_axi_rdata;
    wire [15:0] dq_out, dq_oe_n, dq_in;
    wire [3:0] link_cmd;
    wire [6:0] link_op;
    logic [17:0] d [16];
    logic [31:0] q [$];
    int errors, cmp_count;
    dqtf_top u_dut (.*);
    dqtf_ctl u_ctl (.*);
    // 10 MHz
    initial forever #50 aclk = ~aclk;
    task chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %0t %h %h", $time, g, e);
        end
    endtask
    // Driven pins only; undriven lanes are masked to zero before the compare
    always @(posedge link_ck)
        if (!(&{mask_inversion_pin_oe_n, dq_oe_n}))
            chk({mask_inversion_pin_out & ~mask_inversion_pin_oe_n, dq_out & ~dq_oe_n},
                q.size() ? q.pop_front() : 32'hFFFFFFFF);
    function automatic logic [17:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[17:0];
    endfunction
    // One write or read; each channel released once taken
    task axi(input w, input [7:0] a, input [31:0] v, input [1:0] r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_bvalid | s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        chk(w ? s_axi_bresp : s_axi_rresp, r);
        if (!w) chk(s_axi_rdata, v);
    endtask
    task finish_test;
        $display("cmp_count=%0d errors=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, about thirteen times the planned run
    initial
    begin
        #2000000;
        errors++;
        finish_test;
    end
    initial
    begin
        foreach (d[i]) d[i] = xs();
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++)
            axi(0, 8'(4 * i), i ? (i > 1 ? 32'h55 : 32'h3C) : 32'h5A, 2'h0);
        axi(0, 8'h40, 32'h0, 2'h2);
        axi(1, 8'h18, 32'h0, 2'h2);
        $display("registers done");
        for (int n = 0; n < 16; n++)
            q.push_back(((32'h3C5A >> n) & 1) * 32'hFF ^ 32'h55);
        u_ctl.train(7'h43, d);
        u_ctl.train(7'h47, d);
        axi(0, 8'h18, 32'h01, 2'h0);
        foreach (d[n]) q.push_back({16'h0, d[n][15:0]});
        u_ctl.train(7'h41, d);
        axi(0, 8'h18, 32'h11, 2'h0);
        u_ctl.train(7'h01, d);
        axi(0, 8'h18, 32'h11, 2'h0);
        // Upper lane, read inversion on, programmed pattern and mask
        axi(1, 8'h00, 32'h96, 2'h0);
        axi(0, 8'h00, 32'h96, 2'h0);
        axi(1, 8'h0C, 32'h0F, 2'h0);
        axi(1, 8'h10, 32'h40, 2'h0);
        axi(1, 8'h14, 32'h1080E, 2'h0);
        for (int n = 0; n < 16; n++)
            q.push_back(((32'h3C96 >> n) & 1) * 32'h2FF00 ^ 32'hF00);
        u_ctl.train(7'h43, d);
        // Six reads from one land on two only if pointers wrap at five
        repeat (6) u_ctl.lk(4'h3, 7'h0, 18'h0, 1'b0, 1'b1);
        axi(0, 8'h18, 32'h22, 2'h0);
        u_ctl.lk(4'h0, 7'h0, 18'h0, 1'b0, 1'b0);
        axi(0, 8'h18, 32'h00, 2'h0);
        u_ctl.lk(4'h3, 7'h0, 18'h0, 1'b0, 1'b1);
        u_ctl.link_reset_n <= 1'b0;
        u_ctl.lk(4'h0, 7'h0, 18'h0, 1'b0, 1'b1);
        axi(0, 8'h18, 32'h00, 2'h0);
        chk(q.size(), 0);
        $display("training done");
        finish_test;
    end
endmodule // tb
